//--- ecgp_chan_fifo.v
`timescale 1ns/1ps

module ecgp_chan_fifo #(
    parameter WIDTH = 3,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_in,
    input  wire             reset_n_in,
    input  wire             push_in,
    input  wire [WIDTH-1:0] push_data_in,
    output wire             push_ready_out,
    input  wire             pop_in,
    output reg  [WIDTH-1:0] head_out,
    output wire             empty_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_q;
    reg [AW:0]      rd_ptr_q;
    wire            full;
    wire            do_push;
    wire            do_pop;

    assign empty_out      = (wr_ptr_q == rd_ptr_q);
    assign full           = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) &&
                            (wr_ptr_q[AW] != rd_ptr_q[AW]);
    assign push_ready_out = ~full;
    assign do_push        = push_in & ~full;
    assign do_pop         = pop_in & ~empty_out;

    always @(posedge clk_in)
    begin
        if (do_push)
            mem[wr_ptr_q[AW-1:0]] <= push_data_in;
    end

    always @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (do_pop)
                rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

    always @*
    begin
        head_out = mem[rd_ptr_q[AW-1:0]];
    end
endmodule

//--- ecgp_ctrl.v
`timescale 1ns/1ps
`include "ecgp_defs.vh"

module ecgp_ctrl #(
    parameter NCH   = 8,
    parameter NGRP  = 4,
    parameter SW    = 8,
    parameter CHW   = 3,
    parameter DEPTH = 16,
    parameter FAW   = 4
) (
    input  wire                  clk_in,
    input  wire                  reset_n_in,
    input  wire                  frame_in,
    input  wire [`ECGP_AW-1:0]   addr_in,
    input  wire [7:0]            wdata_in,
    input  wire                  wr_in,
    input  wire                  rd_in,
    output reg  [7:0]            rdata_out,
    output reg                   rdata_oe_out,
    output wire                  irq_n_out,
    input  wire [NCH-1:0]        tone_in,
    input  wire [NCH*SW-1:0]     rin_in,
    input  wire [NCH*SW-1:0]     sin_in,
    input  wire [NCH*SW-1:0]     proc_rout_in,
    input  wire [NCH*SW-1:0]     proc_sout_in,
    output wire [NCH*SW-1:0]     rout_out,
    output wire [NCH*SW-1:0]     sout_out,
    output wire [NCH-1:0]        coef_clear_out,
    output wire [NCH-1:0]        adapt_freeze_out,
    output wire [NCH-1:0]        rx_atten_out,
    output wire [NCH-1:0]        noise_off_out,
    output wire [NCH-1:0]        b2b_out,
    output wire [NCH-1:0]        ext_delay_out,
    output wire [NGRP-1:0]       group_power_out
);
    // ****************************************
    // Register storage
    // ****************************************
    reg  [7:0]       ctrl1_q [0:NCH-1];
    reg  [7:0]       main_q  [0:NGRP-1];
    reg  [NGRP-1:0]  pwr_prev_q;
    reg  [NCH-1:0]   tone_prev_q;
    reg  [NCH-1:0]   pend_q;
    reg  [NCH-1:0]   pend_d;
    reg              irq_gap_q;
    reg  [CHW-1:0]   pick;
    reg              pick_vld;
    reg  [7:0]       rd_mux;
    integer          k;
    integer          j;

    wire             gmask;
    wire             fifo_empty;
    wire             fifo_ready;
    wire [CHW-1:0]   fifo_head;
    wire             ch_hit;
    wire [CHW-1:0]   ch_sel;
    wire [4:0]       ch_ofs;
    wire             main_hit;
    wire [1:0]       main_sel;
    wire             fifo_hit;
    wire             fifo_pop;
    wire [NGRP-1:0]  pwr_rise;
    wire [NCH-1:0]   tone_edge;
    wire [NCH-1:0]   tone_en;
    wire [NCH-1:0]   ctrl1_we;
    wire             main_we;
    wire             c1_hit;
    wire             st_hit;
    wire             irq_want;

    // ****************************************
    // Address decode
    // ****************************************
    assign ch_sel   = addr_in[`ECGP_CH_STRIDE_LSB+CHW-1:`ECGP_CH_STRIDE_LSB];
    assign ch_ofs   = addr_in[`ECGP_CH_STRIDE_LSB-1:0];
    // Only channel blocks that exist decode; aliases above them read as zero
    assign ch_hit   = ~|addr_in[`ECGP_AW-1:`ECGP_CH_STRIDE_LSB+CHW];
    assign main_hit = (addr_in >= `ECGP_MAIN_BASE) && (addr_in <= `ECGP_MAIN_LAST);
    assign main_sel = addr_in[1:0];
    assign fifo_hit = (addr_in == `ECGP_IRQ_FIFO);
    assign fifo_pop = rd_in & fifo_hit;
    assign c1_hit   = ch_hit && (ch_ofs == `ECGP_OFS_CTRL1);
    assign st_hit   = ch_hit && (ch_ofs == `ECGP_OFS_STATUS);
    assign main_we  = wr_in && main_hit;

    assign gmask = main_q[0][`ECGP_M_GLOBAL_MSK];

    // ****************************************
    // Per-group power and per-channel controls
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : g_ch
            // ****************************************
            // Control outputs of this channel
            // ****************************************
            wire pwr = main_q[g/2][`ECGP_M_PWR_UP];
            assign ctrl1_we[g]         = wr_in & c1_hit & (ch_sel == g);
            assign coef_clear_out[g]   = ctrl1_q[g][`ECGP_C1_BYPASS] |
                                         pwr_rise[g/2];
            assign adapt_freeze_out[g] = ctrl1_q[g][`ECGP_C1_ADAPT_OFF] |
                                         ctrl1_q[g][`ECGP_C1_BYPASS];
            assign rx_atten_out[g]     = ctrl1_q[g][`ECGP_C1_RX_ATTEN];
            assign noise_off_out[g]    = ctrl1_q[g][`ECGP_C1_NOISE_OFF];
            assign b2b_out[g]          = ctrl1_q[g][`ECGP_C1_B2B];
            assign ext_delay_out[g]    = ctrl1_q[g][`ECGP_C1_EXT_DELAY];
            // Odd channels are canceller B of their group
            assign tone_en[g] = ~gmask & ~main_q[g/2][(g % 2 == 1) ?
                                `ECGP_M_TONE_MSK_B : `ECGP_M_TONE_MSK_A];
            assign tone_edge[g] = tone_in[g] ^ tone_prev_q[g];

            // ****************************************
            // Sample path of this channel
            // ****************************************
            ecgp_pcm_path #(
                .SW (SW)
            ) u_path (
                .clk_in        (clk_in),
                .reset_n_in    (reset_n_in),
                .frame_in      (frame_in),
                .power_down_in (~pwr),
                .bypass_in     (ctrl1_q[g][`ECGP_C1_BYPASS]),
                .rin_in        (rin_in[g*SW +: SW]),
                .sin_in        (sin_in[g*SW +: SW]),
                .proc_rout_in  (proc_rout_in[g*SW +: SW]),
                .proc_sout_in  (proc_sout_in[g*SW +: SW]),
                .rout_out      (rout_out[g*SW +: SW]),
                .sout_out      (sout_out[g*SW +: SW])
            );
        end

        // ****************************************
        // Group power
        // ****************************************
        for (g = 0; g < NGRP; g = g + 1)
        begin : g_grp
            assign group_power_out[g] = main_q[g][`ECGP_M_PWR_UP];
            assign pwr_rise[g] = main_q[g][`ECGP_M_PWR_UP] & ~pwr_prev_q[g];
        end
    endgenerate

    // ****************************************
    // Register writes
    // ****************************************
    always @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            for (k = 0; k < NCH; k = k + 1)
                ctrl1_q[k] <= `ECGP_CTRL1_RESET;
            for (k = 0; k < NGRP; k = k + 1)
                main_q[k] <= `ECGP_MAIN_RESET;
            pwr_prev_q <= {NGRP{1'b0}};
        end
        else
        begin
            pwr_prev_q <= group_power_out;
            for (k = 0; k < NCH; k = k + 1)
            begin
                // Power-up initialisation restores the defaults
                if (pwr_rise[k/2])
                    ctrl1_q[k] <= `ECGP_CTRL1_RESET;
                // Reserved bit 1 is always stored as zero
                else if (ctrl1_we[k])
                    ctrl1_q[k] <= wdata_in & `ECGP_CTRL1_WMASK;
            end
            if (main_we)
                main_q[main_sel] <= wdata_in;
        end
    end

    // ****************************************
    // Tone event capture and queueing
    // ****************************************
    // Events wait in pending bits so simultaneous edges all get queued
    always @*
    begin
        pick     = {CHW{1'b0}};
        pick_vld = 1'b0;
        // Lowest channel wins the single push of each cycle
        for (j = NCH - 1; j >= 0; j = j - 1)
        begin
            if (pend_q[j])
            begin
                pick     = j[CHW-1:0];
                pick_vld = 1'b1;
            end
        end
        pend_d = pend_q;
        if (pick_vld && fifo_ready)
            pend_d[pick] = 1'b0;
        // Set wins over the clear of the same bit
        pend_d = pend_d | (tone_edge & tone_en);
    end

    always @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            tone_prev_q <= {NCH{1'b0}};
            pend_q      <= {NCH{1'b0}};
            irq_gap_q   <= 1'b0;
        end
        else
        begin
            tone_prev_q <= tone_in;
            pend_q      <= pend_d;
            irq_gap_q   <= fifo_pop;
        end
    end

    // ****************************************
    // Interrupt queue
    // ****************************************
    ecgp_chan_fifo #(
        .WIDTH (CHW),
        .DEPTH (DEPTH),
        .AW    (FAW)
    ) u_fifo (
        .clk_in         (clk_in),
        .reset_n_in     (reset_n_in),
        .push_in        (pick_vld),
        .push_data_in   (pick),
        .push_ready_out (fifo_ready),
        .pop_in         (fifo_pop),
        .head_out       (fifo_head),
        .empty_out      (fifo_empty)
    );

    // ****************************************
    // Interrupt request line
    // ****************************************
    // One cycle high after each queue read separates the low pulses
    assign irq_want  = ~fifo_empty & ~gmask & ~irq_gap_q;
    assign irq_n_out = ~irq_want;

    // ****************************************
    // Register reads
    // ****************************************
    always @*
    begin
        rd_mux = 8'h00;
        case ({fifo_hit, main_hit, st_hit, c1_hit})
            4'h1:
                rd_mux = ctrl1_q[ch_sel];
            4'h2:
                rd_mux[`ECGP_ST_TONE] = tone_in[ch_sel];
            4'h4:
                rd_mux = main_q[main_sel];
            4'h8:
            begin
                if (!fifo_empty)
                begin
                    rd_mux[CHW-1:0]          = fifo_head;
                    rd_mux[`ECGP_FIFO_VALID] = 1'b1;
                end
            end
            default:
                rd_mux = 8'h00;
        endcase
    end

    // ****************************************
    // Read data register
    // ****************************************
    always @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            rdata_out    <= 8'h00;
            rdata_oe_out <= 1'b0;
        end
        else
        begin
            rdata_oe_out <= rd_in;
            if (rd_in)
                rdata_out <= rd_mux;
        end
    end
endmodule

//--- ecgp_ctrl_asserts.sv
`timescale 1ns/1ps
`include "ecgp_defs.vh"

// ****************************************
// Port checker
// ****************************************
module ecgp_ctrl_asserts #(
    parameter NCH  = 8,
    parameter NGRP = 4
) (
    input wire                clk_in,
    input wire                reset_n_in,
    input wire [`ECGP_AW-1:0] addr_in,
    input wire [7:0]          wdata_in,
    input wire                wr_in,
    input wire                rd_in,
    input wire [7:0]          rdata_out,
    input wire                irq_n_out,
    input wire [NCH-1:0]      tone_in,
    input wire [NCH-1:0]      coef_clear_out,
    input wire [NCH-1:0]      adapt_freeze_out,
    input wire [NCH-1:0]      rx_atten_out,
    input wire [NCH-1:0]      noise_off_out,
    input wire [NCH-1:0]      b2b_out,
    input wire [NCH-1:0]      ext_delay_out,
    input wire [NGRP-1:0]     group_power_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    reg  [2:0]     ch_q;
    reg  [7:0]     wd_q;
    reg  [NCH-1:0] chmask_q;
    reg            gmask_q;
    reg  [NGRP-1:0] pw_q;
    reg            rise_q;
    wire           wc = wr_in && addr_in[10:8] == 3'd0 && addr_in[4:0] == 5'h00;
    wire           fr = rd_in && addr_in == `ECGP_IRQ_FIFO;
    // Mirror of the mask bits, so tone checks know what may interrupt
    always @(posedge clk_in)
    begin
        ch_q   <= addr_in[7:5];
        wd_q   <= wdata_in;
        // A control write in a power-up rise cycle loses to the defaults
        pw_q   <= group_power_out;
        rise_q <= group_power_out[addr_in[7:6]] & ~pw_q[addr_in[7:6]];
        if (!reset_n_in)
        begin
            chmask_q <= {NCH{1'b0}};
            gmask_q  <= 1'b0;
        end
        else if (wr_in && addr_in[10:2] == 9'h100)
        begin
            chmask_q[addr_in[1:0]*2]   <= wdata_in[3];
            chmask_q[addr_in[1:0]*2+1] <= wdata_in[4];
            if (addr_in[1:0] == 2'd0)
                gmask_q <= wdata_in[5];
        end
    end
    a_power_bit: assert property (wr_in && addr_in[10:2] == 9'h100
        |=> group_power_out[$past(addr_in[1:0])] == wd_q[0]) else $error("power bit");
    a_tone_raises: assert property (!gmask_q && !rd_in && !fr
        && ((tone_in ^ $past(tone_in)) & ~chmask_q) != 0 |-> ##[1:2] !irq_n_out)
        else $error("tone edge gave no request");
    a_fifo_entry: assert property (fr && !irq_n_out |=> rdata_out[3])
        else $error("request but queue read empty");
    a_fifo_gap: assert property (fr |=> irq_n_out) else $error("no gap after read");
    a_gmask_high: assert property (gmask_q |-> irq_n_out) else $error("masked request");
    a_ctrl_layout: assert property (wc |=> {noise_off_out[ch_q], b2b_out[ch_q],
        ext_delay_out[ch_q]} == ({wd_q[6], wd_q[5], wd_q[0]} & {3{~rise_q}}))
        else $error("ctrl bits");
    a_bypass_ctl: assert property (wc && wdata_in[3]
        |=> (coef_clear_out[ch_q] && adapt_freeze_out[ch_q]) || rise_q)
        else $error("bypass ctl");
    a_adapt_off: assert property (wc
        |=> adapt_freeze_out[ch_q] == ((wd_q[2] | wd_q[3]) & ~rise_q))
        else $error("adapt freeze");
    a_atten_bit: assert property (wc |=> rx_atten_out[ch_q] == (wd_q[4] & ~rise_q))
        else $error("rx atten");
endmodule

bind ecgp_ctrl ecgp_ctrl_asserts #(.NCH(NCH), .NGRP(NGRP)) ecgp_ctrl_asserts_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_n_out(irq_n_out),
    .tone_in(tone_in), .coef_clear_out(coef_clear_out), .adapt_freeze_out(adapt_freeze_out),
    .rx_atten_out(rx_atten_out), .noise_off_out(noise_off_out), .b2b_out(b2b_out),
    .ext_delay_out(ext_delay_out), .group_power_out(group_power_out));

//--- ecgp_defs.vh
`ifndef ECGP_DEFS_VH
`define ECGP_DEFS_VH

// ****************************************
// Address map
// ****************************************
`define ECGP_AW            11
`define ECGP_CH_STRIDE_LSB 5
`define ECGP_OFS_CTRL1     5'h00
`define ECGP_OFS_STATUS    5'h02
`define ECGP_MAIN_BASE     11'h400
`define ECGP_MAIN_LAST     11'h403
`define ECGP_IRQ_FIFO      11'h404

// ****************************************
// Control register 1 fields
// ****************************************
`define ECGP_CTRL1_RESET   8'h00
`define ECGP_CTRL1_WMASK   8'hfd
`define ECGP_C1_SOFT_RST   7
`define ECGP_C1_NOISE_OFF  6
`define ECGP_C1_B2B        5
`define ECGP_C1_RX_ATTEN   4
`define ECGP_C1_BYPASS     3
`define ECGP_C1_ADAPT_OFF  2
`define ECGP_C1_EXT_DELAY  0

// ****************************************
// Main control and status fields
// ****************************************
`define ECGP_MAIN_RESET    8'h00
`define ECGP_M_PWR_UP      0
`define ECGP_M_TONE_MSK_A  3
`define ECGP_M_TONE_MSK_B  4
`define ECGP_M_GLOBAL_MSK  5
`define ECGP_ST_TONE       0
`define ECGP_FIFO_VALID    3

`endif

//--- ecgp_dsp_model.sv
`timescale 1ns/1ps

// ****************************************
// Processing stand-in
// ****************************************
// Inverts samples so processed data never looks like bypassed data
module ecgp_dsp_model #(
    parameter W = 64
) (
    input  wire [W-1:0] rin_in,
    input  wire [W-1:0] sin_in,
    output wire [W-1:0] rout_out,
    output wire [W-1:0] sout_out
);
    assign rout_out = ~rin_in;
    assign sout_out = ~sin_in;
endmodule

//--- ecgp_pcm_path.v
`timescale 1ns/1ps

module ecgp_pcm_path #(
    parameter SW = 8
) (
    input  wire          clk_in,
    input  wire          reset_n_in,
    input  wire          frame_in,
    input  wire          power_down_in,
    input  wire          bypass_in,
    input  wire [SW-1:0] rin_in,
    input  wire [SW-1:0] sin_in,
    input  wire [SW-1:0] proc_rout_in,
    input  wire [SW-1:0] proc_sout_in,
    output reg  [SW-1:0] rout_out,
    output reg  [SW-1:0] sout_out
);
    // Two frame-spaced stages give the powered-down delay
    reg [SW-1:0] r1_q;
    reg [SW-1:0] r2_q;
    reg [SW-1:0] s1_q;
    reg [SW-1:0] s2_q;

    always @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            r1_q     <= {SW{1'b0}};
            r2_q     <= {SW{1'b0}};
            s1_q     <= {SW{1'b0}};
            s2_q     <= {SW{1'b0}};
            rout_out <= {SW{1'b0}};
            sout_out <= {SW{1'b0}};
        end
        else if (frame_in)
        begin
            r1_q <= rin_in;
            r2_q <= r1_q;
            s1_q <= sin_in;
            s2_q <= s1_q;
            if (power_down_in)
            begin
                rout_out <= r2_q;
                sout_out <= s2_q;
            end
            else if (bypass_in)
            begin
                rout_out <= rin_in;
                sout_out <= sin_in;
            end
            else
            begin
                rout_out <= proc_rout_in;
                sout_out <= proc_sout_in;
            end
        end
    end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`include "ecgp_defs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end

// ****************************************
// Bench
// ****************************************
module tb_top;
    logic        clk_in = 0, reset_n_in = 0, frame_in = 0, wr_in = 0, rd_in = 0;
    logic [10:0] addr_in = 0;
    logic [7:0]  wdata_in = 0, tone_in = 0, exp_v;
    logic [63:0] rin_in = 0, sin_in = 0, rv[4], sv[4];
    logic [31:0] rs = 32'h830a_0619;
    logic [7:0]  expq[$];
    wire  [63:0] pr, ps, rout_out, sout_out;
    wire  [7:0]  rdata_out, cc, af, ra, no, bb, ed;
    wire  [3:0]  gp;
    wire         rdata_oe_out, irq_n_out;
    int          mismatches = 0, tests_run = 0, cyc = 0, i;
    always #2 clk_in = ~clk_in;
    ecgp_dsp_model ecgp_dsp_model_i (.rin_in(rin_in), .sin_in(sin_in),
        .rout_out(pr), .sout_out(ps));
    ecgp_ctrl ecgp_ctrl_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .frame_in(frame_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .rdata_oe_out(rdata_oe_out), .irq_n_out(irq_n_out),
        .tone_in(tone_in), .rin_in(rin_in), .sin_in(sin_in), .proc_rout_in(pr),
        .proc_sout_in(ps), .rout_out(rout_out), .sout_out(sout_out),
        .coef_clear_out(cc), .adapt_freeze_out(af), .rx_atten_out(ra),
        .noise_off_out(no), .b2b_out(bb), .ext_delay_out(ed), .group_power_out(gp));
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task conclude();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input [10:0] a, input [7:0] d);
        @(negedge clk_in);
        addr_in = a; wdata_in = d; wr_in = 1;
        @(negedge clk_in);
        wr_in = 0;
    endtask
    task rd(input [10:0] a, input [7:0] e);
        @(negedge clk_in);
        addr_in = a; rd_in = 1; expq.push_back(e);
        @(negedge clk_in);
        rd_in = 0;
    endtask
    task frm();
        @(negedge clk_in);
        frame_in = 1;
        @(negedge clk_in);
        frame_in = 0;
    endtask
    task tone(input [7:0] t);
        @(negedge clk_in);
        tone_in = t;
        repeat (4) @(negedge clk_in);
    endtask
    // Read data is judged where it appears, against the oldest note
    always @(negedge clk_in)
        if (rdata_oe_out === 1'b1)
        begin
            exp_v = expq.pop_front();
            `CHK(rdata_out, exp_v);
        end
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            conclude();
        end
    end
    initial
    begin
        repeat (8) @(negedge clk_in);
        reset_n_in = 1;
        rd(11'h000, 8'h00);
        rd(11'h7ff, 8'h00);
        `CHK(gp, 4'h0);
        for (i = 0; i < 4; i++)
        begin
            rv[i] = {xs(), xs()};
            sv[i] = {xs(), xs()};
            rin_in = rv[i];
            sin_in = sv[i];
            frm();
            if (i >= 2)
                `CHK({rout_out, sout_out}, {rv[i-2], sv[i-2]});
        end
        wr(11'h400, 8'h01);
        `CHK(gp, 4'h1);
        wr(11'h000, 8'h5f);
        wr(11'h020, 8'h04);
        rd(11'h000, 8'h5d);
        `CHK({cc[1:0], af[1:0], ra[1:0]}, 6'b01_11_01);
        `CHK({no[0], bb[0], ed[0]}, 3'b101);
        rin_in = {xs(), xs()};
        sin_in = {xs(), xs()};
        frm();
        `CHK({rout_out[7:0], sout_out[7:0]}, {rin_in[7:0], sin_in[7:0]});
        `CHK(rout_out[15:8], ~rin_in[15:8]);
        wr(11'h000, 8'h00);
        `CHK({cc[0], af[0], ra[0]}, 3'b000);
        wr(11'h400, 8'h00);
        `CHK(gp, 4'h0);
        tone(8'h04);
        `CHK(irq_n_out, 1'b0);
        rd(11'h404, 8'h0a);
        `CHK(irq_n_out, 1'b1);
        rd(11'h042, 8'h01);
        tone(8'h20);
        rd(11'h404, 8'h0a);
        `CHK(irq_n_out, 1'b1);
        @(negedge clk_in);
        `CHK(irq_n_out, 1'b0);
        rd(11'h404, 8'h0d);
        @(negedge clk_in);
        `CHK(irq_n_out, 1'b1);
        rd(11'h404, 8'h00);
        wr(11'h401, 8'h08);
        tone(8'h24);
        `CHK(irq_n_out, 1'b1);
        tone(8'h2c);
        rd(11'h404, 8'h0b);
        wr(11'h400, 8'h20);
        tone(8'h24);
        `CHK(irq_n_out, 1'b1);
        rd(11'h404, 8'h00);
        repeat (3) @(negedge clk_in);
        conclude();
    end
endmodule
